// ---- core/bank_select_attribute_logic.sv ----
`timescale 1ns/100ps
// What this block does
// - A bank with valid bit clear is never selected and gives no answer.
// - After reset, bank zero becomes valid when the boot select pin asks.
// - Write-protected bank: writes get no select, no ack, set status flag.
// - Parity checked on bank reads only while its parity enable is set.
// - No parity checking for asynchronous external master cycles.
// - Native-master SRAM writes negate chip select one phase early if set.
// - Burst-host SRAM writes negate chip select one phase early if set.
// - Async external SRAM cycles ignore both early negates and relax.
// - Burst ack enable acknowledges SRAM bursts and drives beat address bits.
// - Relax (never burst host) delays selects one phase, DRAM strobes two, adds one clock.
// - Function code compared under its mask for a bank hit.
// - Internal hits compare upper 21 base bits and function code.
// - External compare uses top lines unless they carry byte strobes.
// - DRAM bank: DRAM timing, address mux by global enable, miss ends row.
// - Port size codes: 32, 16, 8 bit, or external size acknowledge.
// - Internal ack drives size lines; external mode only samples them.
// - Burst host SRAM cycles get transfer ack; external mode samples it.
// - Size ack sampled on all but burst host cycles and ends the cycle even when internal.
// - Page mode only for internal or native masters, never burst host.
module bank_select_attribute_logic (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic boot_cs_enable,
  input wire logic [1:0] boot_port_size,
  input wire logic acc_valid,
  input bank_attr_pkg::access_t acc,
  input wire logic [1:0] data_size_ack_i,
  output logic [1:0] data_size_ack_o,
  output logic data_size_ack_oe,
  input wire logic transfer_ack_i,
  output logic transfer_ack_o,
  output logic transfer_ack_oe,
  input wire logic parity_error_i,
  output logic [7:0] chip_select_n,
  output logic [1:0] burst_address_pins,
  output logic prev_row_negate,
  output logic cycle_done,
  output bank_attr_pkg::cycle_attr_t attr
);

  localparam int NB = bank_attr_pkg::NUM_BANKS;

  // Register byte offset to bank index, bank slots only
  function automatic logic [2:0] bank_of(input logic [7:0] ofs);
    bank_of = ofs[5:3];
  endfunction : bank_of

  // True when the offset lands in the per-bank area
  function automatic logic in_bank_area(input logic [7:0] ofs);
    in_bank_area = ofs < (bank_attr_pkg::BANK_STRIDE * 8'h08);
  endfunction : in_bank_area

  // Size acknowledge code asserted for a given port size
  function automatic logic [1:0] size_code(input logic [1:0] ps);
    unique case (ps)
      bank_attr_pkg::PS_32: size_code = 2'h3;
      bank_attr_pkg::PS_16: size_code = 2'h2;
      bank_attr_pkg::PS_8: size_code = 2'h1;
      default: size_code = 2'h0;
    endcase
  endfunction : size_code

  logic [31:0] base_q [NB];
  logic [31:0] option_q [NB];
  logic [8:0] memory_status_register_q;
  logic [1:0] gcfg_q;
  logic boot_pending_q;

  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] bus_ofs_q;
  logic [31:0] rdata_q;
  logic take;

  logic [8:0] memory_status_register_set;
  logic [8:0] memory_status_register_clr;

  logic [NB-1:0] hit;
  logic any_hit;
  logic [2:0] sel;
  logic [31:0] sel_base;
  logic [31:0] sel_opt;

  bank_attr_pkg::cyc_state_t state_q;
  bank_attr_pkg::access_t acc_q;
  bank_attr_pkg::cycle_attr_t attr_q;
  bank_attr_pkg::cycle_attr_t attr_d;
  logic [4:0] wait_q;
  logic [1:0] beat_q;
  logic [1:0] ps_q;
  logic ext_resp_q;
  logic [7:0] cs_n_q;
  logic [1:0] baddr_q;
  logic page_valid_q;
  logic [2:0] open_bank_q;
  logic [19:0] open_row_q;
  logic row_negate_q;

  logic start;
  logic wp_block;
  logic sram;
  logic ignore_timing;
  logic relax;
  logic burst_host;
  logic page_allowed;
  logic int_ack;
  logic ext_ack;
  logic beat_end;
  logic last_beat;

  // AHB slave: zero-wait writes, one wait state on reads
  assign take = hsel & hready & htrans[1];
  assign hreadyout = ~rd_pend_q;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      bus_ofs_q <= 8'h00;
    end
    else
    begin
      wr_pend_q <= take & hwrite;
      rd_pend_q <= take & ~hwrite;
      if (take)
        bus_ofs_q <= haddr[7:0];
    end
  end

  // Read data registered in the wait cycle so a write just before is seen
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rdata_q <= 32'h0000_0000;
    else if (rd_pend_q)
    begin
      if (in_bank_area(bus_ofs_q) && bus_ofs_q[2] == 1'b0)
        rdata_q <= base_q[bank_of(bus_ofs_q)];
      else if (in_bank_area(bus_ofs_q))
        rdata_q <= option_q[bank_of(bus_ofs_q)];
      else if (bus_ofs_q == bank_attr_pkg::MEMORY_STATUS_REGISTER_OFS)
        rdata_q <= {23'h000000, memory_status_register_q};
      else if (bus_ofs_q == bank_attr_pkg::GCFG_OFS)
        rdata_q <= {30'h00000000, gcfg_q};
      else
        rdata_q <= 32'h0000_0000;
    end
  end

  // Boot straps caught on the first edge after reset release
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      boot_pending_q <= 1'b1;
    else
      boot_pending_q <= 1'b0;
  end

  // Bank register pairs; boot load loses to nothing since no bus write
  // can reach this block before the first edge completes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < NB; i++)
      begin
        base_q[i] <= bank_attr_pkg::BR_RESET;
        option_q[i] <= bank_attr_pkg::OR_RESET;
      end
    end
    else if (boot_pending_q)
    begin
      base_q[0][bank_attr_pkg::BR_VALID_BIT] <= boot_cs_enable;
      option_q[0][bank_attr_pkg::OR_SPS_LSB +: 2] <= boot_port_size;
    end
    else if (wr_pend_q && in_bank_area(bus_ofs_q))
    begin
      if (bus_ofs_q[2] == 1'b0)
        base_q[bank_of(bus_ofs_q)] <= hwdata;
      else
        option_q[bank_of(bus_ofs_q)] <= hwdata;
    end
  end

  // Global config: sync external master and address mux enable
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      gcfg_q <= 2'h0;
    else if (wr_pend_q && bus_ofs_q == bank_attr_pkg::GCFG_OFS)
      gcfg_q <= hwdata[1:0];
  end

  // Status: write one to clear, a new event in the same cycle wins
  assign memory_status_register_clr = (wr_pend_q && bus_ofs_q == bank_attr_pkg::MEMORY_STATUS_REGISTER_OFS) ?
                     hwdata[8:0] : 9'h000;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      memory_status_register_q <= 9'h000;
    else
      memory_status_register_q <= (memory_status_register_q & ~memory_status_register_clr) | memory_status_register_set;
  end

  // One comparator per bank
  for (genvar g = 0; g < NB; g++)
  begin : g_match
    bank_match u_match (
      .base(base_q[g]),
      .option(option_q[g]),
      .acc(acc),
      .hit(hit[g])
    );
  end

  // Lowest bank wins when regions overlap
  always_comb
  begin
    sel = 3'h0;
    any_hit = 1'b0;
    for (int i = NB - 1; i >= 0; i--)
    begin
      if (hit[i])
      begin
        sel = i[2:0];
        any_hit = 1'b1;
      end
    end
  end

  assign sel_base = base_q[sel];
  assign sel_opt = option_q[sel];

  // Start-of-cycle attribute decode
  always_comb
  begin
    burst_host = acc.master == bank_attr_pkg::MST_BURST_HOST;
    sram = ~sel_opt[bank_attr_pkg::OR_DRAM_SELECT_BIT];
    wp_block = sel_base[bank_attr_pkg::BR_WP_BIT] & acc.write;
    ignore_timing = (acc.master != bank_attr_pkg::MST_INTERNAL) &
                    ~gcfg_q[bank_attr_pkg::GC_SYNC_BIT] & sram;
    relax = sel_base[bank_attr_pkg::BR_TRLX_BIT] & ~ignore_timing &
            ~burst_host;
    page_allowed = ~sram & sel_opt[bank_attr_pkg::OR_PAGE_MODE_ENABLE_BIT] &
                   ~burst_host;
    attr_d.bank = sel;
    attr_d.dram = ~sram;
    attr_d.addr_mux = ~sram & gcfg_q[bank_attr_pkg::GC_GLOBAL_ADDRESS_MUX_ENABLE_BIT];
    attr_d.cs_delay_phases = relax ? bank_attr_pkg::CS_RELAX_PHASES :
                             2'h0;
    attr_d.cas_delay_phases = (relax && !sram) ?
                              bank_attr_pkg::CAS_RELAX_PHASES :
                              2'h0;
    attr_d.cs_early_negate = sram & acc.write & ~ignore_timing &
      ((~burst_host & sel_base[bank_attr_pkg::BR_CSN_NATIVE_BIT])
       | (burst_host & sel_base[bank_attr_pkg::BR_CSN_BURST_BIT]));
    // Async external masters have no parity support at all
    attr_d.parity_check = sel_base[bank_attr_pkg::BR_PARITY_CHECK_ENABLE_BIT] &
      ~((acc.master != bank_attr_pkg::MST_INTERNAL) &
        ~gcfg_q[bank_attr_pkg::GC_SYNC_BIT]);
    attr_d.page_mode = page_allowed;
    attr_d.page_hit = page_allowed & page_valid_q & (open_bank_q == sel) &
                      (open_row_q == acc.addr[31:12]);
    attr_d.burst_ack = burst_host & acc.burst & sram &
                       sel_base[bank_attr_pkg::BR_BACK_BIT];
  end

  assign start = (state_q == bank_attr_pkg::ST_IDLE) & acc_valid & any_hit &
                 ~wp_block;

  // Write-protect event flag, and parity events per bank on read acks
  always_comb
  begin
    memory_status_register_set = 9'h000;
    memory_status_register_set[bank_attr_pkg::MS_WRITE_PROTECT_ERROR_BIT] = (state_q ==
      bank_attr_pkg::ST_IDLE) & acc_valid & any_hit & wp_block;
    if (beat_end && !acc_q.write && attr_q.parity_check && parity_error_i)
      memory_status_register_set[attr_q.bank] = 1'b1;
  end

  // Ends of a beat: internal count done, or an external acknowledge
  always_comb
  begin
    int_ack = (state_q == bank_attr_pkg::ST_WAIT) & (wait_q == 5'h00) &
              ~ext_resp_q;
    if (acc_q.master == bank_attr_pkg::MST_BURST_HOST)
      ext_ack = ext_resp_q & transfer_ack_i;
    else
      ext_ack = data_size_ack_i != 2'h0;
    beat_end = (state_q == bank_attr_pkg::ST_WAIT) & (int_ack | ext_ack);
    last_beat = ~attr_q.burst_ack | (beat_q == bank_attr_pkg::BURST_LAST_BEAT);
  end

  // Acknowledge drivers; size lines released whenever not acking
  always_comb
  begin
    data_size_ack_oe = int_ack &
      (acc_q.master != bank_attr_pkg::MST_BURST_HOST);
    data_size_ack_o = data_size_ack_oe ? size_code(ps_q) : 2'h0;
    transfer_ack_oe = int_ack &
      (acc_q.master == bank_attr_pkg::MST_BURST_HOST);
    transfer_ack_o = transfer_ack_oe;
  end

  assign cycle_done = beat_end & last_beat;

  // Cycle sequencer: wait states per beat, burst beat counting
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= bank_attr_pkg::ST_IDLE;
      acc_q <= '0;
      attr_q <= '0;
      wait_q <= 5'h00;
      beat_q <= 2'h0;
      ps_q <= 2'h0;
      ext_resp_q <= 1'b0;
      cs_n_q <= 8'hFF;
      baddr_q <= 2'h0;
    end
    else
    begin
      unique case (state_q)
        bank_attr_pkg::ST_IDLE:
        begin
          if (start)
          begin
            state_q <= bank_attr_pkg::ST_WAIT;
            acc_q <= acc;
            attr_q <= attr_d;
            // Relax adds one whole clock to the wait count
            wait_q <= {1'b0, sel_opt[bank_attr_pkg::OR_CYCLE_LENGTH_FIELD_LSB +: 4]} +
                      (relax ? bank_attr_pkg::RELAX_EXTRA_CLOCKS :
                       5'h00);
            beat_q <= 2'h0;
            // DRAM banks ack as 32 bit and never wait for an outside ack
            ps_q <= sram ? sel_opt[bank_attr_pkg::OR_SPS_LSB +: 2] :
                    bank_attr_pkg::PS_32;
            ext_resp_q <= sram & (sel_opt[bank_attr_pkg::OR_SPS_LSB +: 2]
                          == bank_attr_pkg::PS_EXT);
            cs_n_q <= ~(8'h01 << sel);
            baddr_q <= acc.addr[3:2];
          end
        end
        bank_attr_pkg::ST_WAIT:
        begin
          if (beat_end && last_beat)
          begin
            state_q <= bank_attr_pkg::ST_IDLE;
            cs_n_q <= 8'hFF;
          end
          else if (beat_end)
          begin
            // Later beats reuse the programmed length
            beat_q <= beat_q + 2'h1;
            baddr_q <= baddr_q + 2'h1;
            wait_q <= {1'b0, option_q[attr_q.bank]
                       [bank_attr_pkg::OR_CYCLE_LENGTH_FIELD_LSB +: 4]};
          end
          else if (wait_q != 5'h00)
            wait_q <= wait_q - 5'h01;
        end
      endcase
    end
  end

  // Open DRAM row tracking; a page miss ends the previous row
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      page_valid_q <= 1'b0;
      open_bank_q <= 3'h0;
      open_row_q <= 20'h00000;
      row_negate_q <= 1'b0;
    end
    else
    begin
      row_negate_q <= 1'b0;
      if (start && !sram)
      begin
        row_negate_q <= page_valid_q & ~attr_d.page_hit;
        page_valid_q <= page_allowed;
        open_bank_q <= sel;
        open_row_q <= acc.addr[31:12];
      end
    end
  end

  assign chip_select_n = cs_n_q;
  assign burst_address_pins = baddr_q;
  assign prev_row_negate = row_negate_q;
  assign attr = attr_q;

endmodule : bank_select_attribute_logic

// ---- core/bank_attr_pkg.sv ----
package bank_attr_pkg;

  // Bank count and register map
  localparam int NUM_BANKS = 8;
  localparam logic [7:0] BANK_STRIDE = 8'h08;
  localparam logic [7:0] BASE_OFS = 8'h00;
  localparam logic [7:0] OPTION_OFS = 8'h04;
  localparam logic [7:0] MEMORY_STATUS_REGISTER_OFS = 8'h40;
  localparam logic [7:0] GCFG_OFS = 8'h44;

  // bank_base_register fields
  localparam int BR_VALID_BIT = 0;
  localparam int BR_WP_BIT = 1;
  localparam int BR_PARITY_CHECK_ENABLE_BIT = 2;
  localparam int BR_CSN_NATIVE_BIT = 3;
  localparam int BR_CSN_BURST_BIT = 4;
  localparam int BR_BACK_BIT = 5;
  localparam int BR_TRLX_BIT = 6;
  localparam int BR_FC_LSB = 7;
  localparam int BR_BA_LSB = 11;
  localparam logic [31:0] BR_RESET = 32'h0000_0050;

  // bank_option_register fields
  localparam int OR_DRAM_SELECT_BIT = 0;
  localparam int OR_SPS_LSB = 1;
  localparam int OR_PAGE_MODE_ENABLE_BIT = 3;
  localparam int OR_FCM_LSB = 7;
  localparam int OR_AM_LSB = 11;
  localparam int OR_CYCLE_LENGTH_FIELD_LSB = 28;
  localparam logic [31:0] OR_RESET = 32'hF000_0000;

  // memory_status_register and global config fields
  localparam int MS_WRITE_PROTECT_ERROR_BIT = 8;
  localparam int GC_SYNC_BIT = 0;
  localparam int GC_GLOBAL_ADDRESS_MUX_ENABLE_BIT = 1;

  // Timing figures in phases and clocks
  localparam logic [1:0] CS_RELAX_PHASES = 2'h1;
  localparam logic [1:0] CAS_RELAX_PHASES = 2'h2;
  localparam logic [4:0] RELAX_EXTRA_CLOCKS = 5'h01;
  localparam logic [1:0] BURST_LAST_BEAT = 2'h3;

  typedef enum logic [1:0] {
    PS_32 = 2'h0,
    PS_16 = 2'h1,
    PS_8 = 2'h2,
    PS_EXT = 2'h3
  } port_size_t;

  typedef enum logic [1:0] {
    MST_INTERNAL = 2'h0,
    MST_EXT_NATIVE = 2'h1,
    MST_BURST_HOST = 2'h2
  } master_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_WAIT = 2'h2
  } cyc_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [3:0] fc;
    logic write;
    master_t master;
    logic burst;
    logic strobe_mode;
  } access_t;

  typedef struct packed {
    logic [2:0] bank;
    logic dram;
    logic addr_mux;
    logic [1:0] cs_delay_phases;
    logic [1:0] cas_delay_phases;
    logic cs_early_negate;
    logic parity_check;
    logic page_mode;
    logic page_hit;
    logic burst_ack;
  } cycle_attr_t;

endpackage : bank_attr_pkg

// ---- core/bank_match.sv ----
`timescale 1ns/100ps
module bank_match (
  input wire logic [31:0] base,
  input wire logic [31:0] option,
  input bank_attr_pkg::access_t acc,
  output logic hit
);

  logic [20:0] cmp_mask;
  logic addr_ok;
  logic fc_ok;

  // Address compare over the 21 base bits, low part maskable
  always_comb
  begin
    cmp_mask = {4'hF, option[bank_attr_pkg::OR_AM_LSB +: 17]};
    // Top four lines carry byte strobes for external masters here
    if (acc.master != bank_attr_pkg::MST_INTERNAL && acc.strobe_mode)
      cmp_mask[20:17] = 4'h0;
    addr_ok = ((acc.addr[31:11] ^ base[bank_attr_pkg::BR_BA_LSB +: 21])
               & cmp_mask) == 21'h000000;
    fc_ok = ((acc.fc ^ base[bank_attr_pkg::BR_FC_LSB +: 4])
             & option[bank_attr_pkg::OR_FCM_LSB +: 4]) == 4'h0;
    hit = base[bank_attr_pkg::BR_VALID_BIT] & addr_ok & fc_ok;
  end

endmodule : bank_match

// ---- bench/bank_attr_checker.sv ----
`timescale 1ns/100ps
module bank_attr_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] data_size_ack_i,
  input wire logic [1:0] data_size_ack_o,
  input wire logic data_size_ack_oe,
  input wire logic transfer_ack_oe,
  input wire logic [7:0] chip_select_n,
  input wire logic [1:0] burst_address_pins,
  input wire logic cycle_done,
  input bank_attr_pkg::cycle_attr_t attr
);
  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Any select low means a cycle runs
  wire logic busy = chip_select_n != 8'hFF;

  // Burst beat ends with more to come
  sequence mid_beat_s;
    transfer_ack_oe && attr.burst_ack && !cycle_done;
  endsequence

  // Outside size ack while selected
  sequence ext_ack_s;
    busy && data_size_ack_i != 2'h0 && !attr.burst_ack;
  endsequence

  ack_needs_cs_a: assert property (
    (data_size_ack_oe || transfer_ack_oe) |-> busy)
    else $error("Ack given with no select");
  dsack_done_a: assert property (
    data_size_ack_oe |-> cycle_done)
    else $error("Size ack without cycle end");
  dsack_code_a: assert property (
    data_size_ack_oe |-> data_size_ack_o != 2'h0)
    else $error("Size ack code empty");
  ext_ack_a: assert property (
    ext_ack_s |-> cycle_done)
    else $error("Outside size ack did not end cycle");
  done_free_a: assert property (
    cycle_done |=> chip_select_n == 8'hFF)
    else $error("Select held after cycle end");
  cs_hold_a: assert property (
    (busy && !cycle_done) |=> $stable(chip_select_n))
    else $error("Select dropped mid cycle");
  burst_step_a: assert property (
    mid_beat_s |=> burst_address_pins == $past(burst_address_pins) + 2'h1)
    else $error("Beat address did not advance");
  // Column strobe delay exists only on DRAM banks
  relax_pair_a: assert property (
    attr.cs_delay_phases != 2'h0 |->
    attr.cs_delay_phases == 2'h1 &&
    attr.cas_delay_phases == (attr.dram ? 2'h2 : 2'h0))
    else $error("Relax phases wrong");
  early_sram_a: assert property (
    attr.cs_early_negate |-> !attr.dram)
    else $error("Early negate on DRAM bank");
  page_burst_a: assert property (
    attr.page_mode |-> !attr.burst_ack)
    else $error("Page mode on burst");
endmodule : bank_attr_checker

// ---- bench/mem_partner.sv ----
`timescale 1ns/100ps
module mem_partner (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [7:0] chip_select_n,
  input wire logic [3:0] ack_dly,
  input wire logic use_ta,
  input wire logic par_err,
  output logic [1:0] data_size_ack_i,
  output logic transfer_ack_i,
  output logic parity_error_i
);
  logic [3:0] cnt_q;
  logic sel;
  logic ack;

  // Cycles since the select went low
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      cnt_q <= 4'h0;
    else
      cnt_q <= sel ? cnt_q + 4'h1 : 4'h0;

  // Ack only once selected, up and down in one cycle
  assign sel = chip_select_n != 8'hFF;
  assign ack = sel && ack_dly != 4'h0 && cnt_q == ack_dly - 4'h1;
  assign data_size_ack_i = (ack && !use_ta) ? 2'h3 : 2'h0;
  assign transfer_ack_i = ack && use_ta;
  // Bad parity across the whole selected cycle
  assign parity_error_i = par_err && sel;
endmodule : mem_partner

// ---- bench/testbench.sv ----
`timescale 1ns/100ps
module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic hready, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic boot_cs_enable = 1'b1;
  logic [1:0] boot_port_size = 2'h0;
  logic acc_valid = 1'b0;
  bank_attr_pkg::access_t acc = '0;
  logic [1:0] data_size_ack_i, data_size_ack_o, burst_address_pins, dsg;
  logic data_size_ack_oe, transfer_ack_i, transfer_ack_o, transfer_ack_oe;
  logic parity_error_i, prev_row_negate, cycle_done, prn;
  logic [7:0] chip_select_n, csa, pseq;
  bank_attr_pkg::cycle_attr_t attr;
  logic [3:0] ack_dly = 4'h0;
  logic use_ta = 1'b0;
  logic par_err = 1'b0;
  int mismatches = 0;
  int checked = 0;
  int n, tan;

  // One slave, so its ready is the bus ready
  assign hready = hreadyout;
  always #5 hclk = ~hclk;

  bank_select_attribute_logic u_dut (.*);
  mem_partner u_mem (.hclk, .hresetn, .chip_select_n, .ack_dly, .use_ta,
    .par_err, .data_size_ack_i, .transfer_ack_i, .parity_error_i);

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task final_report;
    if (mismatches == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  // Bus tasks start and end just after a rising edge
  task bus_wr(input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : bus_wr

  task bus_rd(input logic [31:0] a, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= 1'b0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus_rd

  // One memory request; a miss runs out at 20 cycles
  task mem(input logic [31:0] a, input logic w = 1'b0,
    input logic [1:0] m = 2'h0, input logic b = 1'b0,
    input logic [3:0] f = 4'h5, input logic s = 1'b0);
    acc <= '{addr:a, fc:f, write:w, master:bank_attr_pkg::master_t'(m),
      burst:b, strobe_mode:s};
    acc_valid <= 1'b1;
    @(posedge hclk);
    acc_valid <= 1'b0;
    n = 0;
    tan = 0;
    csa = 8'hFF;
    prn = 1'b0;
    dsg = 2'h0;
    do
    begin
      @(posedge hclk);
      n++;
      csa &= chip_select_n;
      prn |= prev_row_negate;
      if (data_size_ack_oe === 1'b1)
        dsg = data_size_ack_o;
      if (transfer_ack_oe === 1'b1)
      begin
        tan++;
        pseq = {pseq[5:0], burst_address_pins};
        chk(32'(transfer_ack_o), 32'h1);
      end
    end while (cycle_done !== 1'b1 && n < 20);
    @(posedge hclk);
  endtask : mem

  task t_reset;
    bus_rd(32'h0, rd);
    chk(rd, 32'h51);
    bus_rd(32'h4, rd);
    chk(rd, 32'hF000_0000);
    bus_rd(32'h8, rd);
    chk(rd, 32'h50);
    bus_rd(32'h80, rd);
    chk(rd, 32'h0);
    chk(32'(hresp), 32'h0);
  endtask : t_reset

  task t_invalid;
    bus_wr(32'h4, 32'h0);
    bus_wr(32'h0, 32'h50);
    mem(32'h1000);
    chk(32'(csa), 32'hFF);
    chk(32'(n), 32'h14);
    bus_wr(32'h0, 32'h1);
  endtask : t_invalid

  task t_sizes;
    for (int s = 0; s < 3; s++)
    begin
      bus_wr(32'h4, 32'(s) << 1);
      mem(32'h1000);
      chk(32'(dsg), 32'(3 - s));
      chk(32'(n), 32'h1);
      chk(32'(csa), 32'hFE);
    end
    // Outside ack beats a long internal count
    bus_wr(32'h4, 32'h4000_0000);
    ack_dly <= 4'h2;
    mem(32'h1000);
    chk(32'(n), 32'h2);
    bus_wr(32'h4, 32'h6);
    ack_dly <= 4'h3;
    mem(32'h1000);
    chk(32'(n), 32'h3);
    use_ta <= 1'b1;
    ack_dly <= 4'h2;
    mem(32'h1000, 1'b0, 2'h2);
    chk(32'(n), 32'h2);
    use_ta <= 1'b0;
    ack_dly <= 4'h0;
    bus_wr(32'h4, 32'h0);
    mem(32'h1000, 1'b0, 2'h2);
    chk(32'(tan), 32'h1);
  endtask : t_sizes

  task t_wprot;
    bus_wr(32'h0, 32'h3);
    mem(32'h1000, 1'b1);
    chk(32'(csa), 32'hFF);
    bus_rd(32'h40, rd);
    chk(rd, 32'h100);
    mem(32'h1000);
    chk(32'(n), 32'h1);
    bus_wr(32'h40, 32'h100);
    bus_rd(32'h40, rd);
    chk(rd, 32'h0);
  endtask : t_wprot

  task t_relax;
    bus_wr(32'h0, 32'h41);
    bus_wr(32'h44, 32'h1);
    mem(32'h1000);
    chk(32'(n), 32'h2);
    chk(32'(attr.cs_delay_phases), 32'h1);
    chk(32'(attr.cas_delay_phases), 32'h0);
    bus_wr(32'h44, 32'h0);
    mem(32'h1000, 1'b0, 2'h1);
    chk(32'(attr.cs_delay_phases), 32'h0);
    bus_wr(32'h0, 32'h9);
    mem(32'h1000, 1'b1);
    chk(32'(attr.cs_early_negate), 32'h1);
    mem(32'h1000, 1'b1, 2'h1);
    chk(32'(attr.cs_early_negate), 32'h0);
    // Burst host is external: early negate needs the sync mode
    bus_wr(32'h44, 32'h1);
    bus_wr(32'h0, 32'h11);
    mem(32'h1000, 1'b1, 2'h2);
    chk(32'(attr.cs_early_negate), 32'h1);
    bus_wr(32'h0, 32'h1);
  endtask : t_relax

  task t_fc;
    bus_wr(32'h0, 32'h0010_0281);
    bus_wr(32'h4, 32'h0FFF_FF80);
    mem(32'h0010_0000);
    chk(32'(n), 32'h1);
    mem(32'h0010_0000, 1'b0, 2'h0, 1'b0, 4'h6);
    chk(32'(n), 32'h14);
    mem(32'h0020_0000);
    chk(32'(n), 32'h14);
    mem(32'h1010_0000);
    chk(32'(n), 32'h14);
    mem(32'h1010_0000, 1'b0, 2'h1);
    chk(32'(n), 32'h14);
    mem(32'h1010_0000, 1'b0, 2'h1, 1'b0, 4'h5, 1'b1);
    chk(32'(n), 32'h1);
    bus_wr(32'h0, 32'h1);
    bus_wr(32'h4, 32'h0);
  endtask : t_fc

  task t_parity;
    bus_wr(32'h0, 32'h5);
    bus_wr(32'h44, 32'h1);
    par_err <= 1'b1;
    mem(32'h1000);
    bus_rd(32'h40, rd);
    chk(rd, 32'h1);
    bus_wr(32'h40, 32'h1);
    bus_wr(32'h44, 32'h0);
    mem(32'h1000, 1'b0, 2'h1);
    bus_rd(32'h40, rd);
    chk(rd, 32'h0);
    bus_wr(32'h0, 32'h1);
    mem(32'h1000);
    bus_rd(32'h40, rd);
    chk(rd, 32'h0);
    par_err <= 1'b0;
  endtask : t_parity

  task t_burst;
    bus_wr(32'h0, 32'h21);
    pseq = 8'h00;
    mem(32'h1004, 1'b0, 2'h2, 1'b1);
    chk(32'(tan), 32'h4);
    chk(32'(pseq), 32'h6C);
    bus_wr(32'h0, 32'h1);
    mem(32'h1004, 1'b0, 2'h2, 1'b1);
    chk(32'(tan), 32'h1);
  endtask : t_burst

  task t_page;
    bus_wr(32'h44, 32'h2);
    bus_wr(32'h4, 32'h9);
    bus_wr(32'h0, 32'h41);
    mem(32'h1000);
    chk(32'(attr.cas_delay_phases), 32'h2);
    mem(32'h1004);
    chk(32'(attr.page_hit), 32'h1);
    chk(32'(attr.dram), 32'h1);
    chk(32'(attr.addr_mux), 32'h1);
    mem(32'h2000);
    chk(32'(prn), 32'h1);
    mem(32'h2000, 1'b0, 2'h2);
    chk(32'(attr.page_mode), 32'h0);
  endtask : t_page

  // Main sequence after a long reset
  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_reset;
    t_invalid;
    t_sizes;
    t_wprot;
    t_relax;
    t_fc;
    t_parity;
    t_burst;
    t_page;
    final_report;
  end

  // Hang guard, far beyond the expected run
  initial
  begin
    #200000;
    mismatches++;
    final_report;
  end
endmodule : testbench

bind bank_select_attribute_logic bank_attr_checker u_chk (.hclk(hclk),
  .hresetn(hresetn), .data_size_ack_i(data_size_ack_i),
  .data_size_ack_o(data_size_ack_o), .data_size_ack_oe(data_size_ack_oe),
  .transfer_ack_oe(transfer_ack_oe), .chip_select_n(chip_select_n),
  .burst_address_pins(burst_address_pins), .cycle_done(cycle_done),
  .attr(attr));
